// [dss_defines.svh]
// Register offsets, reset values and timing counts for speed supervision
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_CTRL     8'h00
`define OFF_RATIO    8'h04
`define OFF_PERIOD   8'h08
`define OFF_BRKDLY   8'h0C
`define OFF_MAXF     8'h10
`define OFF_BASEF    8'h14
`define OFF_OSLVL    8'h18
`define OFF_LIMA     8'h1C
`define OFF_LIMB     8'h20
`define OFF_GAIN1    8'h24
`define OFF_GAIN2    8'h28
`define OFF_RAMP     8'h2C
`define OFF_FFGAIN   8'h30
`define OFF_STATUS   8'h34
`define OFF_MASK     8'h38
`define OFF_STATE    8'h3C
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CODE     3'h0
`define RST_RATIO    16'h0CCC
`define RST_PERIOD   16'h000A
`define RST_BRKDLY   16'h0064
`define RST_MAXF     16'h0258
`define RST_BASEF    16'h01F4
`define RST_OSLVL    16'h006E
`define RST_LIM      16'h0064
`define RST_GAIN     16'h0100
`define RST_RAMP     16'h000A
`define RST_FFGAIN   16'h0000
// ----------------------------------------
// Limits and timing
// ----------------------------------------
`define CODE_MAX     3'h5
`define BRKDLY_MAX   16'h1388
`define OS_LEGACY    16'h03E7
`define OS_ABS_PG    16'h07D0
`define OS_ABS_NOPG  16'h04B0
`define OS_MARGIN    16'h0078
`define PCT          16'h0064
`define PCT2         16'h2710
`define TICK_NS      1000000
`define CLK_NS       50
`endif

// [dss_pkg.sv]
// Types shared by the speed supervision logic
package dss_pkg;
  typedef enum logic [1:0] {
    BRK_RELEASED = 2'b00,
    BRK_TIMING   = 2'b01,
    BRK_ENGAGED  = 2'b10
  } brake_state_t;

  typedef struct packed {
    logic enc_flag;
    logic coast_alarm;
    logic overspeed;
  } fault_t;
endpackage

// [drive_speed_supervision.sv]
// Speed supervision: encoder fault, overspeed, brake timer, servo gain, feed-forward
`timescale 1ns/1ps
`include "dss_defines.svh"

module drive_speed_supervision
  import dss_pkg::*;
#(
  parameter int P_TICK_CYCLES = `TICK_NS / `CLK_NS
)(
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_srst,
  // Register port
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [31:0]        i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic      [31:0]        o_reg_rdata,
  // Speed and drive status
  input  wire logic [15:0]        i_speed_ref,
  input  wire logic [15:0]        i_speed_det,
  input  wire logic               i_torque_ctrl,
  input  wire logic               i_speed_sensor,
  input  wire logic               i_limit_select,
  input  wire logic               i_below_brake_level,
  input  wire logic               i_output_shutdown,
  input  wire logic               i_servo_gain_select_input,
  input  wire logic signed [31:0] i_torque_cmd,
  // Results
  output logic                    o_brake_on,
  output logic                    o_encoder_fault_flag,
  output logic                    o_coast_alarm,
  output logic                    o_overspeed_alarm,
  output logic      [15:0]        o_servo_gain,
  output logic signed [31:0]      o_torque_cmd,
  output logic                    o_irq
);

  function automatic logic [47:0] mul3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    mul3 = 48'(a) * 48'(b) * 48'(c);
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [2:0]  code_reg;
  logic [15:0] ratio_reg, period_reg, brkdly_reg, maxf_reg, basef_reg, oslvl_reg;
  logic [15:0] lima_reg, limb_reg, gain1_reg, gain2_reg, ramp_reg, ffg_reg;
  logic [2:0]  status_reg, mask_reg;
  fault_t      fault_reg;
  logic        wr_status;
  logic [2:0]  ev;

  assign wr_status = i_reg_wr && (i_reg_addr == `OFF_STATUS);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      code_reg   <= `RST_CODE;
      ratio_reg  <= `RST_RATIO;
      period_reg <= `RST_PERIOD;
      brkdly_reg <= `RST_BRKDLY;
      maxf_reg   <= `RST_MAXF;
      basef_reg  <= `RST_BASEF;
      oslvl_reg  <= `RST_OSLVL;
      lima_reg   <= `RST_LIM;
      limb_reg   <= `RST_LIM;
      gain1_reg  <= `RST_GAIN;
      gain2_reg  <= `RST_GAIN;
      ramp_reg   <= `RST_RAMP;
      ffg_reg    <= `RST_FFGAIN;
      mask_reg   <= 3'h0;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        // Out-of-range handling codes are ignored
        `OFF_CTRL:   if (i_reg_wdata[2:0] <= `CODE_MAX) code_reg <= i_reg_wdata[2:0];
        `OFF_RATIO:  ratio_reg  <= i_reg_wdata[15:0];
        `OFF_PERIOD: period_reg <= i_reg_wdata[15:0];
        `OFF_BRKDLY: if (i_reg_wdata[15:0] <= `BRKDLY_MAX) brkdly_reg <= i_reg_wdata[15:0];
        `OFF_MAXF:   maxf_reg   <= i_reg_wdata[15:0];
        `OFF_BASEF:  basef_reg  <= i_reg_wdata[15:0];
        `OFF_OSLVL:  oslvl_reg  <= i_reg_wdata[15:0];
        `OFF_LIMA:   lima_reg   <= i_reg_wdata[15:0];
        `OFF_LIMB:   limb_reg   <= i_reg_wdata[15:0];
        `OFF_GAIN1:  gain1_reg  <= i_reg_wdata[15:0];
        `OFF_GAIN2:  gain2_reg  <= i_reg_wdata[15:0];
        `OFF_RAMP:   ramp_reg   <= i_reg_wdata[15:0];
        `OFF_FFGAIN: ffg_reg    <= i_reg_wdata[15:0];
        `OFF_MASK:   mask_reg   <= i_reg_wdata[2:0];
        default:     ;
      endcase
    end
  end

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic [31:0] tick_cnt;
  logic        tick;

  assign tick = (tick_cnt == 32'(P_TICK_CYCLES - 1));

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || tick)
      tick_cnt <= 32'h0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  // ----------------------------------------
  // Encoder fault detection
  // ----------------------------------------
  logic [15:0] dev, base_w, period_cnt;
  logic        wide, out_w, exempt, excursion, enc_detect, stop_code;

  assign dev    = absdiff(i_speed_ref, i_speed_det);
  assign base_w = 16'((32'(ratio_reg) * 32'(maxf_reg)) >> 16);
  assign wide   = (code_reg >= 3'h3);

  always_comb
  begin
    if (wide && (i_speed_ref > basef_reg))
      out_w = (32'(dev) * 32'(basef_reg)) > (32'(base_w) * 32'(i_speed_ref));
    else
      out_w = dev > base_w;
  end

  assign exempt     = (i_speed_det < i_speed_ref) && (code_reg != 3'h2)
                      && (code_reg != 3'h5);
  assign excursion  = out_w && !exempt;
  assign enc_detect = excursion && (period_cnt >= period_reg);
  assign stop_code  = (code_reg != 3'h0) && (code_reg != 3'h3);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || !excursion)
      period_cnt <= 16'h0;
    else if (tick && (period_cnt != 16'hFFFF))
      period_cnt <= period_cnt + 16'h1;
  end

  // ----------------------------------------
  // Overspeed detection
  // ----------------------------------------
  logic [15:0] lim;
  logic [47:0] det_pct, det_pct2;
  logic        os_hit;

  assign lim      = i_limit_select ? limb_reg : lima_reg;
  assign det_pct  = mul3(i_speed_det, `PCT, 16'h1);
  assign det_pct2 = mul3(i_speed_det, `PCT2, 16'h1);

  always_comb
  begin
    if (oslvl_reg == `OS_LEGACY)
      os_hit = (det_pct2 >= mul3(maxf_reg, lim, `OS_MARGIN))
               || (det_pct2 >= mul3(i_speed_sensor ? `OS_ABS_PG : `OS_ABS_NOPG,
                                    lim, `OS_MARGIN));
    else
      os_hit = det_pct >= mul3(maxf_reg, oslvl_reg, 16'h1);
  end

  // ----------------------------------------
  // Fault latches, status and interrupt
  // ----------------------------------------
  always_comb
  begin
    ev[0] = enc_detect;
    ev[1] = i_torque_ctrl && os_hit;
    ev[2] = 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      fault_reg <= '0;
    else
    begin
      // Hardware set wins over a same-cycle clear
      if (enc_detect)
        fault_reg.enc_flag <= 1'b1;
      else if (wr_status && i_reg_wdata[0])
        fault_reg.enc_flag <= 1'b0;
      if (enc_detect && stop_code)
        fault_reg.coast_alarm <= 1'b1;
      else if (wr_status && i_reg_wdata[0])
        fault_reg.coast_alarm <= 1'b0;
      if (ev[1])
        fault_reg.overspeed <= 1'b1;
      else if (wr_status && i_reg_wdata[1])
        fault_reg.overspeed <= 1'b0;
    end
  end

  // ----------------------------------------
  // Brake-on timer
  // ----------------------------------------
  brake_state_t brk_state_reg, brk_state_next;
  logic [15:0]  brk_cnt;

  always_comb
  begin
    brk_state_next = brk_state_reg;
    case (brk_state_reg)
      BRK_RELEASED:
        if (i_output_shutdown)
          brk_state_next = BRK_ENGAGED;
        else if (i_below_brake_level)
          brk_state_next = BRK_TIMING;
      BRK_TIMING:
        if (i_output_shutdown)
          brk_state_next = BRK_ENGAGED;
        else if (!i_below_brake_level)
          brk_state_next = BRK_RELEASED;
        else if (brk_cnt >= brkdly_reg)
          brk_state_next = BRK_ENGAGED;
      BRK_ENGAGED:
        if (!i_below_brake_level && !i_output_shutdown)
          brk_state_next = BRK_RELEASED;
      default:
        brk_state_next = BRK_ENGAGED;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      brk_state_reg <= BRK_RELEASED;
    else
      brk_state_reg <= brk_state_next;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || (brk_state_reg != BRK_TIMING))
      brk_cnt <= 16'h0;
    else if (tick && (brk_cnt != 16'hFFFF))
      brk_cnt <= brk_cnt + 16'h1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      status_reg <= 3'h0;
    else
      status_reg <= (status_reg & ~((wr_status) ? i_reg_wdata[2:0] : 3'h0))
                    | ev | {brk_state_next == BRK_ENGAGED && brk_state_reg != BRK_ENGAGED,
                            2'b00};
  end

  // ----------------------------------------
  // Servo-lock gain ramp
  // ----------------------------------------
  logic [15:0] gain_tgt, tgt_reg, span_reg, gain_reg;
  logic [31:0] acc_reg, denom;

  assign gain_tgt = i_servo_gain_select_input ? gain2_reg : gain1_reg;
  assign denom    = 32'(ramp_reg) * 32'(P_TICK_CYCLES);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      tgt_reg  <= `RST_GAIN;
      gain_reg <= `RST_GAIN;
      span_reg <= 16'h0;
      acc_reg  <= 32'h0;
    end
    else if (gain_tgt != tgt_reg)
    begin
      tgt_reg  <= gain_tgt;
      span_reg <= absdiff(gain_tgt, gain_reg);
      acc_reg  <= 32'h0;
    end
    else if (gain_reg != tgt_reg)
    begin
      if (denom == 32'h0)
        gain_reg <= tgt_reg;
      else if (acc_reg + 32'(span_reg) >= denom)
      begin
        // One unit step at evenly spread instants over the ramp time
        acc_reg  <= acc_reg + 32'(span_reg) - denom;
        gain_reg <= (tgt_reg > gain_reg) ? gain_reg + 16'h1 : gain_reg - 16'h1;
      end
      else
        acc_reg <= acc_reg + 32'(span_reg);
    end
  end

  // ----------------------------------------
  // Speed feed-forward
  // ----------------------------------------
  logic [15:0]        ref_prev;
  logic signed [31:0] ff_reg;
  logic signed [47:0] ff_w;

  assign ff_w = 48'(signed'({1'b0, ffg_reg})) * 48'(signed'({1'b0, i_speed_ref}))
                - 48'(signed'({1'b0, ffg_reg})) * 48'(signed'({1'b0, ref_prev}));

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      ref_prev <= 16'h0;
      ff_reg   <= 32'sh0;
    end
    else if (tick)
    begin
      ref_prev <= i_speed_ref;
      ff_reg   <= 32'(ff_w * 48'sd10);
    end
  end

  // ----------------------------------------
  // Outputs and read port
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_brake_on           <= 1'b0;
      o_encoder_fault_flag <= 1'b0;
      o_coast_alarm        <= 1'b0;
      o_overspeed_alarm    <= 1'b0;
      o_servo_gain         <= `RST_GAIN;
      o_torque_cmd         <= 32'sh0;
      o_irq                <= 1'b0;
      o_reg_rdata          <= 32'h0;
    end
    else
    begin
      o_brake_on           <= (brk_state_next == BRK_ENGAGED);
      o_encoder_fault_flag <= fault_reg.enc_flag;
      o_coast_alarm        <= fault_reg.coast_alarm;
      o_overspeed_alarm    <= fault_reg.overspeed;
      o_servo_gain         <= gain_reg;
      o_torque_cmd         <= i_torque_cmd + ff_reg;
      o_irq                <= |(status_reg & mask_reg);
      o_reg_rdata          <= 32'h0;
      if (i_reg_rd)
        case (i_reg_addr)
          `OFF_CTRL:   o_reg_rdata <= {29'h0, code_reg};
          `OFF_RATIO:  o_reg_rdata <= {16'h0, ratio_reg};
          `OFF_PERIOD: o_reg_rdata <= {16'h0, period_reg};
          `OFF_BRKDLY: o_reg_rdata <= {16'h0, brkdly_reg};
          `OFF_MAXF:   o_reg_rdata <= {16'h0, maxf_reg};
          `OFF_BASEF:  o_reg_rdata <= {16'h0, basef_reg};
          `OFF_OSLVL:  o_reg_rdata <= {16'h0, oslvl_reg};
          `OFF_LIMA:   o_reg_rdata <= {16'h0, lima_reg};
          `OFF_LIMB:   o_reg_rdata <= {16'h0, limb_reg};
          `OFF_GAIN1:  o_reg_rdata <= {16'h0, gain1_reg};
          `OFF_GAIN2:  o_reg_rdata <= {16'h0, gain2_reg};
          `OFF_RAMP:   o_reg_rdata <= {16'h0, ramp_reg};
          `OFF_FFGAIN: o_reg_rdata <= {16'h0, ffg_reg};
          `OFF_STATUS: o_reg_rdata <= {29'h0, status_reg};
          `OFF_MASK:   o_reg_rdata <= {29'h0, mask_reg};
          `OFF_STATE:  o_reg_rdata <= {gain_reg, 11'h0, brk_state_reg, fault_reg};
          default:     o_reg_rdata <= 32'h0;
        endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_brake_shutdown_now: assert property (i_output_shutdown |=> o_brake_on)
    else $error("brake not engaged after shutdown");
  a_brake_timer_hold: assert property ((brk_state_reg == BRK_TIMING) && !i_output_shutdown
    && (brk_cnt < brkdly_reg) |=> !o_brake_on)
    else $error("brake engaged before delay expired");
  a_enc_detect_flag: assert property (enc_detect |=> ##1 o_encoder_fault_flag)
    else $error("fault flag missing after detection");
  a_enc_coast_code: assert property ($rose(fault_reg.coast_alarm) |-> $past(stop_code))
    else $error("coast alarm on a run-on code");
  a_enc_coast_set: assert property (enc_detect && stop_code |=> fault_reg.coast_alarm)
    else $error("coast alarm missing");
  a_lag_exempt: assert property ((i_speed_det < i_speed_ref) && (code_reg inside {3'h0,
    3'h1, 3'h3, 3'h4}) |-> !excursion)
    else $error("lagging speed flagged");
  a_period_clear: assert property (!excursion |=> (period_cnt == 16'h0))
    else $error("period counter kept count");
  a_overspeed_set: assert property (i_torque_ctrl && os_hit |=> ##1 o_overspeed_alarm)
    else $error("overspeed alarm missing");
  a_ramp_step: assert property (absdiff(gain_reg, $past(gain_reg)) <= 16'h1
    || $past(denom) == 32'h0)
    else $error("servo gain stepped");
  a_code_range: assert property (code_reg <= `CODE_MAX)
    else $error("handling code out of range");

  c_enc_detect: cover property (enc_detect && stop_code);
  c_shutdown_timing: cover property ((brk_state_reg == BRK_TIMING) && i_output_shutdown);
  c_overspeed: cover property (i_torque_ctrl && os_hit && (oslvl_reg == `OS_LEGACY));
  c_gain_ramp: cover property ((gain_reg != tgt_reg) ##1 (gain_reg == tgt_reg));

endmodule

// [enc_feedback_model.sv]
// Encoder feedback model: detected speed follows the command plus an injected error
`timescale 1ns/1ps

module enc_feedback_model (
  // Clock
  input  wire logic               i_core_clk,
  // Command and injected error
  input  wire logic [15:0]        i_speed_ref,
  input  wire logic signed [15:0] i_offset,
  // Feedback to the block
  output logic      [15:0]        o_speed_det
);
  // Registered so feedback trails the command like a real sensor path
  always_ff @(posedge i_core_clk)
  begin
    o_speed_det <= 16'(i_speed_ref + i_offset);
  end
endmodule

// [tb_drive_speed_supervision.sv]
// Self-checking bench for the speed supervision block
`timescale 1ns/1ps
`include "dss_defines.svh"

module tb_drive_speed_supervision;
  import dss_pkg::*;
  localparam int TK = 4;
  localparam logic [7:0] TA [14] = '{`OFF_CTRL, `OFF_RATIO, `OFF_PERIOD, `OFF_BRKDLY,
    `OFF_MAXF, `OFF_BASEF, `OFF_OSLVL, `OFF_LIMA, `OFF_LIMB, `OFF_GAIN1, `OFF_GAIN2,
    `OFF_RAMP, `OFF_FFGAIN, 8'h40};
  localparam logic [15:0] TV [14] = '{16'(`RST_CODE), `RST_RATIO, `RST_PERIOD,
    `RST_BRKDLY, `RST_MAXF, `RST_BASEF, `RST_OSLVL, `RST_LIM, `RST_LIM, `RST_GAIN,
    `RST_GAIN, `RST_RAMP, `RST_FFGAIN, 16'h0000};
  logic               clk, srst, wr, rd, tq, sens, lsel, below, shut, gsel;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata, rs, rv;
  logic [15:0]        ref_spd, det, gain, gs;
  logic signed [15:0] ofs;
  logic signed [31:0] tq_in, tq_out, ts;
  logic               brk, flag, coast, osa, irq;
  logic [4:0]         so;
  int                 bad_count, cmp_count, cyc, n;

  drive_speed_supervision #(.P_TICK_CYCLES(TK)) u_dut (
    .i_core_clk(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_speed_ref(ref_spd),
    .i_speed_det(det), .i_torque_ctrl(tq), .i_speed_sensor(sens),
    .i_limit_select(lsel), .i_below_brake_level(below), .i_output_shutdown(shut),
    .i_servo_gain_select_input(gsel), .i_torque_cmd(tq_in), .o_brake_on(brk),
    .o_encoder_fault_flag(flag), .o_coast_alarm(coast), .o_overspeed_alarm(osa),
    .o_servo_gain(gain), .o_torque_cmd(tq_out), .o_irq(irq));

  enc_feedback_model u_enc (
    .i_core_clk(clk), .i_speed_ref(ref_spd), .i_offset(ofs), .o_speed_det(det));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Mid-cycle snapshots, stable across the next rising edge
  always @(negedge clk)
  begin
    so <= {irq, osa, coast, flag, brk};
    rs <= rdata;
    gs <= gain;
    ts <= tq_out;
  end

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rs;
  endtask

  task automatic waitb(input int b, input int lim);
    n = 0;
    while (so[b] !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 14; i++)
    begin
      rreg(TA[i], rv);
      chk("reset_value", rv, {16'h0000, TV[i]});
    end
    wreg(8'h40, 32'h0000_1234);
    rreg(8'h40, rv);
    chk("unmapped", rv, 32'h0);
    wreg(`OFF_CTRL, 32'h6);
    rreg(`OFF_CTRL, rv);
    chk("code_refused", rv, 32'h0);
    wreg(`OFF_CTRL, 32'h5);
    rreg(`OFF_CTRL, rv);
    chk("code_max", rv, 32'h5);
    wreg(`OFF_BRKDLY, 32'h1389);
    rreg(`OFF_BRKDLY, rv);
    chk("delay_refused", rv, 32'(`RST_BRKDLY));
    wreg(`OFF_BRKDLY, 32'h1388);
    rreg(`OFF_BRKDLY, rv);
    chk("delay_max", rv, 32'h1388);
    $display("test regs done");
  endtask

  task automatic t_enc(input int c, input logic [15:0] r, input int o, input logic f,
                       input logic a);
    ref_spd <= r;
    wreg(`OFF_CTRL, c);
    repeat (2) @(posedge clk);
    ofs <= 16'(o);
    waitb(1, 40);
    chk("enc_flag", so[1], f);
    chk("coast_alarm", so[2], a);
    chk("irq_enc", so[4], f);
    if (f)
      chk("enc_delay", n > TK, 1'b1);
    ofs <= 16'sh0000;
    repeat (4) @(posedge clk);
    wreg(`OFF_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    chk("enc_clear", {so[4], so[2:1]}, 32'h0);
  endtask

  task automatic os_case(input logic [15:0] s, input logic e);
    ref_spd <= s;
    repeat (6) @(posedge clk);
    chk("overspeed", so[3], e);
    chk("irq_masked", so[4], 1'b0);
    ref_spd <= 16'h0000;
    repeat (3) @(posedge clk);
    wreg(`OFF_STATUS, 32'h2);
    repeat (3) @(posedge clk);
  endtask

  task automatic t_os();
    os_case(16'h02D0, 1'b0);
    tq <= 1'b1;
    os_case(16'h0293, 1'b0);
    os_case(16'h0294, 1'b1);
    wreg(`OFF_OSLVL, 32'h3E7);
    os_case(16'h02CF, 1'b0);
    os_case(16'h02D0, 1'b1);
    wreg(`OFF_MAXF, 32'h2710);
    os_case(16'h059F, 1'b0);
    os_case(16'h05A0, 1'b1);
    sens <= 1'b1;
    os_case(16'h095F, 1'b0);
    os_case(16'h0960, 1'b1);
    wreg(`OFF_LIMB, 32'h32);
    lsel <= 1'b1;
    os_case(16'h04AF, 1'b0);
    os_case(16'h04B0, 1'b1);
    tq <= 1'b0;
    $display("test overspeed done");
  endtask

  task automatic t_brk();
    wreg(`OFF_BRKDLY, 32'h3);
    repeat (20) @(posedge clk);
    chk("brake_idle", so[0], 1'b0);
    below <= 1'b1;
    waitb(0, 40);
    chk("brake_on", so[0], 1'b1);
    chk("brake_time", n >= 2 * TK && n <= 4 * TK + 3, 1'b1);
    rreg(`OFF_STATUS, rv);
    chk("brake_event", rv[2], 1'b1);
    below <= 1'b0;
    repeat (4) @(posedge clk);
    chk("brake_release", so[0], 1'b0);
    below <= 1'b1;
    repeat (3) @(posedge clk);
    shut <= 1'b1;
    repeat (2) @(posedge clk);
    chk("brake_shutdown", so[0], 1'b1);
    shut <= 1'b0;
    below <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test brake done");
  endtask

  task automatic t_gain();
    chk("gain_reset", gs, 32'(`RST_GAIN));
    wreg(`OFF_GAIN2, 32'h0104);
    wreg(`OFF_RAMP, 32'h0);
    gsel <= 1'b1;
    repeat (4) @(posedge clk);
    chk("gain_second", gs, 32'h0104);
    wreg(`OFF_RAMP, 32'h4);
    gsel <= 1'b0;
    repeat (4) @(posedge clk);
    chk("gain_ramping", gs > 16'h0100, 1'b1);
    for (n = 0; n < 40 && gs !== 16'h0100; n++)
      @(posedge clk);
    chk("gain_first", gs, 32'h0100);
    $display("test gain done");
  endtask

  task automatic t_ff();
    logic hit;
    hit = 1'b0;
    ref_spd <= 16'h0064;
    tq_in <= 32'sh04D2;
    repeat (12) @(posedge clk);
    chk("ff_zero", ts, 32'h04D2);
    wreg(`OFF_FFGAIN, 32'h1);
    ref_spd <= 16'h0069;
    repeat (12)
    begin
      @(posedge clk);
      hit = hit | (ts === 32'sh0504);
    end
    chk("ff_term", hit, 1'b1);
    repeat (12) @(posedge clk);
    chk("ff_settled", ts, 32'h04D2);
    $display("test feed_forward done");
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  initial
  begin
    {srst, wr, rd, tq, sens, lsel, below, shut, gsel} = 9'h100;
    addr = 8'h00;
    wdata = 32'h0;
    ref_spd = 16'h0000;
    ofs = 16'sh0000;
    tq_in = 32'sh0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    wreg(`OFF_PERIOD, 32'h2);
    wreg(`OFF_MASK, 32'h1);
    for (int c = 0; c < 6; c++)
    begin
      t_enc(c, 16'h012C, -100, c == 2 || c == 5, c == 2 || c == 5);
      t_enc(c, 16'h012C, 100, 1'b1, c != 0 && c != 3);
      t_enc(c, 16'h03E8, 45, c < 3, c == 1 || c == 2);
    end
    $display("test encoder done");
    t_brk();
    t_os();
    t_gain();
    t_ff();
    test_done();
  end
endmodule
